/* File: pof_regs.svh */
`ifndef POF_REGS_SVH
`define POF_REGS_SVH

// Mode selector value that picks raw Bayer output.
`define POF_MODE_RAW_BAYER 1'b1
// Alignment setting value that moves samples to the top of the bus.
`define POF_MSB_ALIGN_ON 1'b1

// Nominal code limits, 8-bit scale.
`define POF_Y8_MIN  8'h10
`define POF_Y8_MAX  8'heb
`define POF_C8_MIN  8'h10
`define POF_C8_MAX  8'hf0
// Nominal code limits, 10-bit scale.
`define POF_Y10_MIN 10'h040
`define POF_Y10_MAX 10'h3ac
`define POF_C10_MIN 10'h040
`define POF_C10_MAX 10'h3c0

// Left shift that MSB-aligns a sample of each width on the 16-bit bus.
`define POF_SHIFT_W8  4'h8
`define POF_SHIFT_W10 4'h6
`define POF_SHIFT_W12 4'h4

`endif

/* File: pof_pkg.sv */
package pof_pkg;

  typedef enum logic [2:0]
  {
    POF_YCC_TWO_CYCLE_NARROW  = 3'h0,
    POF_YCC_TWO_CYCLE_WIDE    = 3'h1,
    POF_YCC_SINGLE_CYCLE_WORD = 3'h2,
    POF_TONEMAPPED_RAW_TEN    = 3'h3,
    POF_TONEMAPPED_RAW_TWELVE = 3'h4
  } pof_fmt_t;

  typedef enum logic [1:0]
  {
    POF_W8  = 2'h0,
    POF_W10 = 2'h1,
    POF_W12 = 2'h2
  } pof_width_t;

  typedef enum logic [1:0]
  {
    POF_PH_IDLE   = 2'b00,
    POF_PH_FIRST  = 2'b01,
    POF_PH_SECOND = 2'b11
  } pof_phase_t;

endpackage

/* File: pof_place.sv */
`timescale 1ns/1ps
`include "pof_regs.svh"

module pof_place
  import pof_pkg::*;
(
  input  wire logic [11:0] i_sample,
  input  wire pof_width_t  i_width,
  input  wire logic        i_msb,
  output logic      [15:0] o_word
);

  logic [15:0] masked;
  logic [3:0]  shift;

  // Bits above the sample width are forced to zero.
  assign masked = (i_width == POF_W8)  ? {8'h00, i_sample[7:0]} :
                  (i_width == POF_W10) ? {6'h00, i_sample[9:0]} :
                                         {4'h0, i_sample};

  assign shift = (i_width == POF_W8)  ? `POF_SHIFT_W8 :
                 (i_width == POF_W10) ? `POF_SHIFT_W10 :
                                        `POF_SHIFT_W12;

  assign o_word = (i_msb == `POF_MSB_ALIGN_ON) ? (masked << shift) : masked; // [R4] [R5] [R13]

endmodule

/* File: pof_top.sv */
`timescale 1ns/1ps
`include "pof_regs.svh"

// Behaviour
// R1: Samples are 8/10-bit, one or two cycles.
// R2: Four chroma/luma orderings via two swap bits.
// R3: Two-cycle modes send chroma then luma.
// R4: MSB align puts samples at [15:8]/[15:6].
// R5: LSB align puts samples at [7:0]/[9:0].
// R6: Word mode sends chroma and luma together.
// R7: Eight-bit codes clip to 16-235/16-240.
// R8: Ten-bit codes clip to 64-940/64-960.
// R9: Default order is Cb, Y, Cr, Y.
// R10: Bayer output only with progressive scan.
// R11: Tone-mapped Bayer zero-fills upper bits.
// R12: Raw Bayer twelve bits, upper four zero.
// R13: Bayer LSB aligned, optionally MSB aligned.
// R14: Host selects raw Bayer with selector one.
// R15: Embedded rows pass only in Bayer formats.
// R16: Settings change only at frame start.
module pof_top
  import pof_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire pof_fmt_t    i_format,
  input  wire logic        i_mode_select,
  input  wire logic        i_swap_cbcr,
  input  wire logic        i_swap_yc,
  input  wire logic        i_msb_align,
  input  wire logic        i_clip_en,
  input  wire logic        i_progressive,
  input  wire logic        i_frame_start,
  input  wire logic        i_line_start,
  input  wire logic        i_pix_valid,
  input  wire logic        i_embedded,
  input  wire logic [9:0]  i_luma,
  input  wire logic [9:0]  i_cb,
  input  wire logic [9:0]  i_cr,
  input  wire logic [11:0] i_bayer_raw,
  input  wire logic [11:0] i_bayer_tm,
  output logic             o_ready,
  output logic             o_dvalid,
  output logic      [15:0] o_dout,
  output logic             o_bayer_blocked
);

  // ****************************************************************
  // Frame-boundary configuration
  // ****************************************************************
  pof_fmt_t fmt_reg;
  logic     raw_reg;
  logic     swap_cbcr_reg;
  logic     swap_yc_reg;
  logic     msb_reg;
  logic     clip_reg;

  // The pixel that carries the frame start already uses the new settings.
  pof_fmt_t fmt_use;
  logic     raw_use;
  logic     swap_cbcr_use;
  logic     swap_yc_use;
  logic     msb_use;
  logic     clip_use;

  assign fmt_use       = i_frame_start ? i_format      : fmt_reg; // [R16]
  assign raw_use       = i_frame_start ? i_mode_select : raw_reg;
  assign swap_cbcr_use = i_frame_start ? i_swap_cbcr   : swap_cbcr_reg;
  assign swap_yc_use   = i_frame_start ? i_swap_yc     : swap_yc_reg;
  assign msb_use       = i_frame_start ? i_msb_align   : msb_reg;
  assign clip_use      = i_frame_start ? i_clip_en     : clip_reg;

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      fmt_reg       <= POF_YCC_TWO_CYCLE_NARROW;
      raw_reg       <= 1'b0;
      swap_cbcr_reg <= 1'b0;
      swap_yc_reg   <= 1'b0;
      msb_reg       <= 1'b0;
      clip_reg      <= 1'b0;
    end
    else
    begin
      fmt_reg       <= fmt_use;
      raw_reg       <= raw_use;
      swap_cbcr_reg <= swap_cbcr_use;
      swap_yc_reg   <= swap_yc_use;
      msb_reg       <= msb_use;
      clip_reg      <= clip_use;
    end
  end

  // ****************************************************************
  // Format decode and pixel acceptance
  // ****************************************************************
  logic raw_sel;
  logic is_bayer;
  logic is_narrow;
  logic is_wide;
  logic two_cycle;
  logic take;
  logic drop;
  logic emit;
  logic chroma_phase_reg;
  logic phase_use;

  assign raw_sel   = (raw_use == `POF_MODE_RAW_BAYER); // [R14]
  assign is_bayer  = raw_sel || (fmt_use == POF_TONEMAPPED_RAW_TEN) || (fmt_use == POF_TONEMAPPED_RAW_TWELVE);
  assign is_narrow = !is_bayer && (fmt_use == POF_YCC_TWO_CYCLE_NARROW);
  assign is_wide   = !is_bayer && (fmt_use == POF_YCC_TWO_CYCLE_WIDE);
  assign two_cycle = is_narrow || is_wide; // [R1]
  assign take      = i_pix_valid && o_ready;
  // Interlaced Bayer is swallowed whole rather than stalling upstream.
  assign drop      = (i_embedded && !is_bayer) || (is_bayer && !i_progressive); // [R10] [R15]
  assign emit      = take && !drop;
  assign phase_use = i_line_start ? 1'b0 : chroma_phase_reg;

  // ****************************************************************
  // Sample selection and clipping
  // ****************************************************************
  logic [9:0] chroma_raw;
  logic [9:0] luma10;
  logic [9:0] chroma10;
  logic [7:0] luma8;
  logic [7:0] chroma8;

  assign chroma_raw = (phase_use ^ swap_cbcr_use) ? i_cr : i_cb; // [R2] [R9]

  assign luma10   = !clip_use ? i_luma :
                    (i_luma < `POF_Y10_MIN) ? `POF_Y10_MIN :
                    (i_luma > `POF_Y10_MAX) ? `POF_Y10_MAX : i_luma; // [R8]
  assign chroma10 = !clip_use ? chroma_raw :
                    (chroma_raw < `POF_C10_MIN) ? `POF_C10_MIN :
                    (chroma_raw > `POF_C10_MAX) ? `POF_C10_MAX : chroma_raw; // [R8]
  assign luma8    = !clip_use ? i_luma[9:2] :
                    (i_luma[9:2] < `POF_Y8_MIN) ? `POF_Y8_MIN :
                    (i_luma[9:2] > `POF_Y8_MAX) ? `POF_Y8_MAX : i_luma[9:2]; // [R7]
  assign chroma8  = !clip_use ? chroma_raw[9:2] :
                    (chroma_raw[9:2] < `POF_C8_MIN) ? `POF_C8_MIN :
                    (chroma_raw[9:2] > `POF_C8_MAX) ? `POF_C8_MAX : chroma_raw[9:2]; // [R7]

  logic [11:0] luma_s;
  logic [11:0] chroma_s;
  logic [11:0] first_s;
  logic [11:0] second_s;
  logic [11:0] bayer_s;
  pof_width_t  width_first;
  pof_width_t  width_second;
  logic [15:0] first_word;
  logic [15:0] second_word;
  logic [15:0] single_word;
  logic [15:0] out_word;

  assign luma_s   = is_wide ? {2'h0, luma10}   : {4'h0, luma8};
  assign chroma_s = is_wide ? {2'h0, chroma10} : {4'h0, chroma8};
  assign bayer_s  = raw_sel ? i_bayer_raw : i_bayer_tm; // [R12]
  // Chroma leads unless the luma-first swap is set.
  assign first_s  = is_bayer ? bayer_s : (swap_yc_use ? luma_s : chroma_s); // [R3] [R2]
  assign second_s = swap_yc_use ? chroma_s : luma_s;

  assign width_second = is_wide ? POF_W10 : POF_W8;
  assign width_first  = !is_bayer ? width_second :
                        (!raw_sel && fmt_use == POF_TONEMAPPED_RAW_TEN) ? POF_W10 : POF_W12; // [R11] [R12]

  pof_place u_place_first
  (
    .i_sample (first_s),
    .i_width  (width_first),
    .i_msb    (msb_use),
    .o_word   (first_word)
  );

  pof_place u_place_second
  (
    .i_sample (second_s),
    .i_width  (width_second),
    .i_msb    (msb_use),
    .o_word   (second_word)
  );

  assign single_word = swap_yc_use ? {luma8, chroma8} : {chroma8, luma8}; // [R6]
  assign out_word    = (is_bayer || two_cycle) ? first_word : single_word;

  // ****************************************************************
  // Output sequencing
  // ****************************************************************
  pof_phase_t  phase_reg;
  pof_phase_t  phase_next;
  logic [15:0] hold_reg;

  always_comb
  begin
    case (phase_reg)
      POF_PH_IDLE:   phase_next = (emit && two_cycle) ? POF_PH_FIRST : POF_PH_IDLE;
      POF_PH_FIRST:  phase_next = POF_PH_SECOND;
      POF_PH_SECOND: phase_next = (emit && two_cycle) ? POF_PH_FIRST : POF_PH_IDLE;
      default:       phase_next = POF_PH_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      phase_reg        <= POF_PH_IDLE;
      hold_reg         <= 16'h0000;
      chroma_phase_reg <= 1'b0;
      o_ready          <= 1'b1;
      o_dvalid         <= 1'b0;
      o_dout           <= 16'h0000;
      o_bayer_blocked  <= 1'b0;
    end
    else
    begin
      phase_reg       <= phase_next;
      o_ready         <= (phase_next != POF_PH_FIRST); // [R3]
      o_bayer_blocked <= is_bayer && !i_progressive; // [R10]
      if (take && !drop && !is_bayer)
        chroma_phase_reg <= !phase_use;
      else if (i_line_start)
        chroma_phase_reg <= 1'b0;
      if (phase_reg == POF_PH_FIRST)
      begin
        o_dvalid <= 1'b1;
        o_dout   <= hold_reg; // [R3]
      end
      else
      begin
        o_dvalid <= emit; // [R15]
        if (emit)
          o_dout <= out_word;
      end
      if (emit)
        hold_reg <= second_word;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  pof_fmt_t out_fmt_reg;
  logic     out_msb_reg;
  logic     out_raw_reg;

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      out_fmt_reg <= POF_YCC_TWO_CYCLE_NARROW;
      out_msb_reg <= 1'b0;
      out_raw_reg <= 1'b0;
    end
    else if (emit)
    begin
      out_fmt_reg <= fmt_use;
      out_msb_reg <= msb_use;
      out_raw_reg <= raw_sel;
    end
  end

  chk_two_cycle_pair: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R1] [R3]
    emit && two_cycle |=> o_dvalid && !o_ready ##1 o_dvalid && o_ready)
    else $error("two-cycle sample pair not emitted");

  chk_single_cycle_word: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R6] [R11]
    emit && !two_cycle && phase_reg != POF_PH_FIRST |=> o_dvalid && o_ready)
    else $error("single-cycle word missing or stalled");

  chk_embedded_drop: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R15]
    take && i_embedded && !is_bayer && phase_reg != POF_PH_FIRST |=> !o_dvalid)
    else $error("embedded row leaked into YCbCr output");

  chk_bayer_interlace: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R10]
    take && is_bayer && !i_progressive |=> o_bayer_blocked && !o_dvalid)
    else $error("Bayer output produced without progressive scan");

  chk_narrow_msb_lane: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R4]
    o_dvalid && !out_raw_reg && out_fmt_reg == POF_YCC_TWO_CYCLE_NARROW && out_msb_reg |-> o_dout[7:0] == 8'h00)
    else $error("narrow sample not on upper byte");

  chk_wide_lsb_lane: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R5]
    o_dvalid && !out_raw_reg && out_fmt_reg == POF_YCC_TWO_CYCLE_WIDE && !out_msb_reg |-> o_dout[15:10] == 6'h00)
    else $error("wide sample not on low ten bits");

  chk_bayer_ten_fill: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R11] [R13]
    o_dvalid && !out_raw_reg && out_fmt_reg == POF_TONEMAPPED_RAW_TEN && !out_msb_reg |-> o_dout[15:10] == 6'h00)
    else $error("ten-bit Bayer upper bits not zero");

  chk_raw_twelve_fill: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R12] [R14]
    o_dvalid && out_raw_reg && !out_msb_reg |-> o_dout[15:12] == 4'h0)
    else $error("raw Bayer upper bits not zero");

  chk_cfg_frame_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R16]
    !$past(i_frame_start) |-> $stable(fmt_reg) && $stable(msb_reg) && $stable(swap_yc_reg) &&
    $stable(swap_cbcr_reg) && $stable(raw_reg) && $stable(clip_reg))
    else $error("format changed away from frame start");

  chk_default_order: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R9] [R2]
    emit && two_cycle && !swap_yc_use && !clip_use && !msb_use && is_narrow && !phase_use && !swap_cbcr_use
    |=> o_dout[7:0] == $past(i_cb[9:2]))
    else $error("default order does not lead with Cb");

  cov_two_cycle: cover property (@(posedge I_CLK) emit && is_narrow ##2 emit && is_narrow);
  cov_word_mode: cover property (@(posedge I_CLK) emit && fmt_use == POF_YCC_SINGLE_CYCLE_WORD && !is_bayer);
  cov_raw_bayer: cover property (@(posedge I_CLK) emit && raw_sel && msb_use);
  cov_embedded:  cover property (@(posedge I_CLK) take && i_embedded && is_bayer && i_progressive);

endmodule

/* File: pof_capture.sv */
`timescale 1ns/1ps

// ****************************************************************
// Downstream capture: records every word the formatter presents.
// ****************************************************************
// The receiver has no way to stall the formatter, so it only
// samples the bus on the cycles that carry a valid word.
module pof_capture
  import pof_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_dvalid,
  input  wire logic [15:0] i_dout
);
  logic [15:0] words[$];

  always @(posedge i_clk)
  begin
    if (!i_rst && i_dvalid === 1'b1)
    begin
      words.push_back(i_dout);
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps

module testbench
  import pof_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        mode_sel;
  logic        swcb;
  logic        swyc;
  logic        msb;
  logic        clip;
  logic        prog;
  logic        fs;
  logic        ls;
  logic        pv;
  logic        emb;
  pof_fmt_t    fmt;
  logic [9:0]  luma;
  logic [9:0]  cb;
  logic [9:0]  cr;
  logic [11:0] braw;
  logic [11:0] btm;
  wire         rdy;
  wire         dv;
  wire         blk;
  wire  [15:0] dout;
  int          bad_count;
  int          checks_done;
  int          seed;
  int          m_fmt;
  int          m_raw;
  int          m_cb;
  int          m_yc;
  int          m_msb;
  int          m_prog;
  int          m_clip;
  int          ph;
  logic [15:0] expq[$];

  pof_top pof_top_inst (.I_CLK(clk), .I_SYS_RST(rst), .i_format(fmt), .i_mode_select(mode_sel),
    .i_swap_cbcr(swcb), .i_swap_yc(swyc), .i_msb_align(msb), .i_clip_en(clip), .i_progressive(prog),
    .i_frame_start(fs), .i_line_start(ls), .i_pix_valid(pv), .i_embedded(emb), .i_luma(luma), .i_cb(cb),
    .i_cr(cr), .i_bayer_raw(braw), .i_bayer_tm(btm), .o_ready(rdy), .o_dvalid(dv), .o_dout(dout),
    .o_bayer_blocked(blk));

  pof_capture pof_capture_inst (.i_clk(clk), .i_rst(rst), .i_dvalid(dv), .i_dout(dout));

  always #50 clk = ~clk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Nominal range limit, applied only while clipping is switched on.
  function automatic int lim(input int v, input int lo, input int hi, input int on);
    return (on != 0 && v < lo) ? lo : ((on != 0 && v > hi) ? hi : v);
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Offers one pixel and predicts the words it must produce under the
  // configuration latched at the frame start.
  task automatic send_pix(input bit first);
    int y;
    int b;
    int r;
    int wr;
    int wt;
    int e;
    int c;
    int n;
    int sh;
    int bay;
    begin
      y = $random(seed) & 1023;
      b = $random(seed) & 1023;
      r = $random(seed) & 1023;
      wr = $random(seed) & 4095;
      wt = $random(seed) & 4095;
      e = (($random(seed) & 3) == 0);
      luma <= 10'(y);
      cb <= 10'(b);
      cr <= 10'(r);
      braw <= 12'(wr);
      btm <= 12'(wt);
      emb <= e[0];
      fs <= first;
      ls <= first;
      pv <= 1'b1;
      if (!first)
      begin
        // Settings that move without a frame start must be ignored.
        {swcb, swyc, msb, mode_sel, clip} <= 5'($random(seed));
        fmt <= pof_fmt_t'(3'($random(seed)));
      end
      bay = m_raw || m_fmt == 3 || m_fmt == 4;
      if (bay && m_prog)
      begin
        sh = m_msb ? ((m_raw || m_fmt == 4) ? 4 : 6) : 0;
        n = m_raw ? wr : (m_fmt == 3 ? (wt & 1023) : wt);
        expq.push_back(16'(n << sh));
      end
      else if (!bay && !e)
      begin
        c = (ph ^ m_cb) ? r : b;
        // Wide mode limits on the ten-bit scale, the other YCbCr modes on the eight-bit scale.
        if (m_fmt == 1)
        begin
          y = lim(y, 64, 940, m_clip);
          c = lim(c, 64, 960, m_clip);
        end
        else
        begin
          y = lim(y >> 2, 16, 235, m_clip);
          c = lim(c >> 2, 16, 240, m_clip);
        end
        if (m_fmt == 0 || m_fmt == 1)
        begin
          sh = m_msb ? ((m_fmt == 0) ? 8 : 6) : 0;
          expq.push_back(16'((m_yc ? y : c) << sh));
          expq.push_back(16'((m_yc ? c : y) << sh));
        end
        else
          expq.push_back(16'(m_yc ? y * 256 + c : c * 256 + y));
        ph ^= 1;
      end
      n = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && n < 50)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 50)
        check("ready", 16'h0001, {15'h0, rdy});
      @(posedge clk);
    end
  endtask

  task automatic run_frame(input int f, input int s);
    int k;
    begin
      m_raw = (f == 5);
      m_fmt = (f == 5) ? ($random(seed) & 3) : f;
      m_cb = s & 1;
      m_yc = (s >> 1) & 1;
      m_msb = (s >> 2) & 1;
      m_prog = (s != 7);
      m_clip = (s ^ f) & 1;
      ph = 0;
      clip <= m_clip[0];
      mode_sel <= m_raw[0];
      fmt <= pof_fmt_t'(3'(m_fmt));
      swcb <= m_cb[0];
      swyc <= m_yc[0];
      msb <= m_msb[0];
      prog <= m_prog[0];
      for (k = 0; k < 6; k++)
        send_pix(k == 0);
      pv <= 1'b0;
      fs <= 1'b0;
      ls <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      k = (m_raw || m_fmt == 3 || m_fmt == 4) && !m_prog;
      check("blocked", 16'(k), {15'h0, blk});
      check("word count", 16'(expq.size()), 16'(pof_capture_inst.words.size()));
      for (k = 0; k < expq.size() && k < pof_capture_inst.words.size(); k++)
        check("word", expq[k], pof_capture_inst.words[k]);
      expq.delete();
      pof_capture_inst.words.delete();
      @(posedge clk);
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial
  begin
    clk = 0;
    rst = 1;
    {mode_sel, swcb, swyc, msb, clip, prog, fs, ls, pv, emb} = 10'h020;
    fmt = POF_YCC_TWO_CYCLE_NARROW;
    {luma, cb, cr, braw, btm} = '0;
    bad_count = 0;
    checks_done = 0;
    seed = 50373;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset ready", 16'h0001, {15'h0, rdy});
    check("reset dvalid", 16'h0000, {15'h0, dv});
    check("reset dout", 16'h0000, dout);
    check("reset blocked", 16'h0000, {15'h0, blk});
    $display("Test reset done");
    @(posedge clk);
    for (int f = 0; f < 6; f++)
    begin
      for (int s = 0; s < 8; s++)
        run_frame(f, s);
      $display("Test format %0d done", f);
    end
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
